/* File: logic/vm_voltage_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vm_defines.svh"

// Summary of operation
// - Common bank select picks channel bank
// - Each bank holds one channel's registers
// - Bank select resets to zero
// - Config bit 0 set starts measuring
// - External reference default; bit1 zero internal
// - Enabled monitor rescans channels every period
// - Settling delay after each conversion
// - Rate register holds period and delay
// - Channel status bit 7 marks completion
// - Result register shows latest result
// - Per-bank high and low limits compared
// - Alarm detection only when bit 4 set
// - Limit crossing sets bit 1 or 2
// - Violation sets channel event status bit
// - Irq route masks gate interrupt output
// - Mgmt route masks gate management interrupt
// - Channels 7, 8, 10 are halved supplies
// - Channel 9 battery undivided, full scale
// - Limit flags stay until software clears
// - Interrupt active when status and enable
// - Result is unsigned 8-bit value
// - Channel bit 0 includes it in scan
module vm_voltage_monitor #(
	parameter int unsigned NCH            = 11,
	parameter int unsigned PERIOD_UNIT_CYC = `VM_PERIOD_UNIT_CYC,
	parameter int unsigned DELAY_UNIT_CYC  = `VM_DELAY_UNIT_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            conv_start,
	output logic      [3:0] conv_chan,
	output logic            conv_ref_ext,
	input  wire logic       conv_done,
	input  wire logic [7:0] conv_data,
	output logic            irq,
	output logic            system_mgmt_interrupt_n
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// First enabled channel at or after a start index; bit 4 = none
	function automatic logic [4:0] vm_find(input logic [NCH-1:0] mask,
	                                      input logic [3:0]     from);
		logic [4:0] r;
		r = 5'h10;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (mask[i] && (4'(i) >= from)) begin
				r = {1'b0, 4'(i)};
			end
		end
		return r;
	endfunction : vm_find

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0]       mon_cfg_q;         // Monitor configuration
	logic [7:0]       rate_q;            // Period and delay select
	logic [7:0]       bank_q;            // Bank select
	logic [NCH-1:0]   evt_q;             // Event status
	logic [NCH-1:0]   irq_mask_q;        // Interrupt routing
	logic [NCH-1:0]   mgmt_mask_q;       // Management routing
	logic [7:0]       cfg_q [NCH];       // Channel config and status
	logic [7:0]       res_q [NCH];       // Channel results
	logic [7:0]       hi_q  [NCH];       // High limits
	logic [7:0]       lo_q  [NCH];       // Low limits
	vm_pkg::vm_state_e state_q;          // Sequencer state
	logic [3:0]       chan_q;            // Channel being converted
	logic [31:0]      per_cnt_q;         // Scan period counter
	logic [31:0]      dly_cnt_q;         // Settling counter
	logic             scan_req_q;        // Pending scan start
	logic [7:0]       rdata_q;           // Read data
	logic             irq_q;             // Interrupt output
	logic             mgmt_n_q;          // Management interrupt, low
	logic [NCH-1:0]   ch_en;             // Channels in the scan
	logic [NCH-1:0]   evt_set;           // Limit violations this cycle

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	wire         mon_en    = mon_cfg_q[`VM_MON_ENABLE];
	wire         bank_ok   = bank_q < 8'(NCH);
	wire  [3:0]  bank_idx  = bank_ok ? bank_q[3:0] : 4'h0;
	wire         wr_evt_lo = reg_wr && (reg_addr == `VM_OFS_EVT_LO);
	wire         wr_evt_hi = reg_wr && (reg_addr == `VM_OFS_EVT_HI);
	wire         wr_mg_hi  = reg_wr && (reg_addr == `VM_OFS_MGMT_HI);
	wire         wr_mg_lo  = reg_wr && (reg_addr == `VM_OFS_MGMT_LO);
	wire         wr_iq_hi  = reg_wr && (reg_addr == `VM_OFS_IRQ_HI);
	wire         wr_iq_lo  = reg_wr && (reg_addr == `VM_OFS_IRQ_LO);
	wire         wr_rate   = reg_wr && (reg_addr == `VM_OFS_RATE);
	wire         wr_mon    = reg_wr && (reg_addr == `VM_OFS_MON_CFG);
	wire         wr_bank   = reg_wr && (reg_addr == `VM_OFS_BANK);
	wire         wr_cfg    = reg_wr && bank_ok && (reg_addr == `VM_OFS_CH_CFG);
	wire         wr_hi     = reg_wr && bank_ok && (reg_addr == `VM_OFS_CH_HI);
	wire         wr_lo     = reg_wr && bank_ok && (reg_addr == `VM_OFS_CH_LO);
	wire  [15:0] evt_w1c   = {wr_evt_hi ? reg_wdata : 8'h00,
	                          wr_evt_lo ? reg_wdata : 8'h00};
	wire  [15:0] evt_wide  = 16'(evt_q);
	wire  [15:0] irq_wide  = 16'(irq_mask_q);
	wire  [15:0] mgmt_wide = 16'(mgmt_mask_q);
	wire         store     = (state_q == vm_pkg::VM_WAIT) && conv_done;

	// Timing selections
	wire  [2:0]  per_sel   = rate_q[`VM_RATE_PER_LSB +: 3];
	wire  [2:0]  dly_sel   = rate_q[`VM_RATE_DLY_LSB +: 3];
	wire  [31:0] per_load  = PERIOD_UNIT_CYC * (32'(per_sel) + 32'd1) - 32'd1;
	wire  [31:0] dly_load  = DELAY_UNIT_CYC * (32'(dly_sel) + 32'd1) - 32'd1;

	// Scan search from start and after the current channel
	wire  [4:0]  first_ch  = vm_find(ch_en, 4'h0);
	wire  [4:0]  next_ch   = vm_find(ch_en, chan_q + 4'h1);

	// ------------------------------------------------------------
	// Read selection
	// ------------------------------------------------------------
	wire  [7:0]  ch_cfg_rd = bank_ok ? cfg_q[bank_idx] : 8'h00;
	wire  [7:0]  ch_res_rd = bank_ok ? res_q[bank_idx] : 8'h00;
	wire  [7:0]  ch_hi_rd  = bank_ok ? hi_q[bank_idx]  : 8'h00;
	wire  [7:0]  ch_lo_rd  = bank_ok ? lo_q[bank_idx]  : 8'h00;
	wire  [7:0]  rd_mux    =
		(reg_addr == `VM_OFS_EVT_LO)  ? evt_wide[7:0]   :
		(reg_addr == `VM_OFS_EVT_HI)  ? evt_wide[15:8]  :
		(reg_addr == `VM_OFS_MGMT_HI) ? mgmt_wide[15:8] :
		(reg_addr == `VM_OFS_MGMT_LO) ? mgmt_wide[7:0]  :
		(reg_addr == `VM_OFS_IRQ_HI)  ? irq_wide[15:8]  :
		(reg_addr == `VM_OFS_IRQ_LO)  ? irq_wide[7:0]   :
		(reg_addr == `VM_OFS_RATE)    ? rate_q          :
		(reg_addr == `VM_OFS_MON_CFG) ? mon_cfg_q       :
		(reg_addr == `VM_OFS_BANK)    ? bank_q          :
		(reg_addr == `VM_OFS_CH_CFG)  ? ch_cfg_rd       :
		(reg_addr == `VM_OFS_CH_RES)  ? ch_res_rd       :
		(reg_addr == `VM_OFS_CH_HI)   ? ch_hi_rd        :
		(reg_addr == `VM_OFS_CH_LO)   ? ch_lo_rd        : 8'h00;

	// ------------------------------------------------------------
	// Common registers
	// ------------------------------------------------------------

	// Monitor config, rate and bank select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mon_cfg_q <= `VM_RST_MON_CFG;
			rate_q    <= `VM_RST_RATE;
			bank_q    <= `VM_RST_BANK;
		end else begin
			if (wr_mon) mon_cfg_q <= reg_wdata;
			if (wr_rate) rate_q <= reg_wdata;
			if (wr_bank) bank_q <= reg_wdata;
		end
	end

	// Routing masks, high register holds channels above seven
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_q  <= '0;
			mgmt_mask_q <= '0;
		end else begin
			if (wr_iq_lo) irq_mask_q[7:0] <= reg_wdata;
			if (wr_iq_hi) irq_mask_q[NCH-1:8] <= reg_wdata[NCH-9:0];
			if (wr_mg_lo) mgmt_mask_q[7:0] <= reg_wdata;
			if (wr_mg_hi) mgmt_mask_q[NCH-1:8] <= reg_wdata[NCH-9:0];
		end
	end

	// Event status, a new violation wins over the clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_q <= '0;
		end else begin
			evt_q <= (evt_q & ~evt_w1c[NCH-1:0]) | evt_set;
		end
	end

	// Interrupt outputs, registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q    <= 1'b0;
			mgmt_n_q <= 1'b1;
		end else begin
			irq_q    <= |(evt_q & irq_mask_q);
			mgmt_n_q <= ~|(evt_q & mgmt_mask_q);
		end
	end

	// Read data captured on a read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= `VM_RST_ZERO;
		end else if (reg_rd) begin
			rdata_q <= rd_mux;
		end
	end

	// ------------------------------------------------------------
	// Channel banks
	// ------------------------------------------------------------
	// Channels 7, 8 and 10 carry halved supplies and 9 the battery
	// undivided; the scaling is analog, the logic treats all alike.
	for (genvar g = 0; g < NCH; g++) begin : g_ch
		wire sel  = (bank_idx == 4'(g));
		wire here = store && (chan_q == 4'(g));
		wire alm  = cfg_q[g][`VM_CH_ALARM_EN];
		wire hi_x = here && alm && (conv_data > hi_q[g]);
		wire lo_x = here && alm && (conv_data < lo_q[g]);
		wire [7:0] clr = (wr_cfg && sel) ? (reg_wdata & `VM_CH_W1C_MASK) : 8'h00;

		assign ch_en[g]   = cfg_q[g][`VM_CH_ENABLE];
		assign evt_set[g] = hi_x || lo_x;

		// Config and status byte of one channel
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				cfg_q[g] <= `VM_RST_ZERO;
			end else begin
				if (wr_cfg && sel) begin
					cfg_q[g] <= (reg_wdata & `VM_CH_RW_MASK)
					          | (cfg_q[g] & ~`VM_CH_RW_MASK & ~clr);
				end else begin
					cfg_q[g] <= cfg_q[g] & ~clr;
				end
				if (hi_x) cfg_q[g][`VM_CH_HI_FLAG] <= 1'b1;
				if (lo_x) cfg_q[g][`VM_CH_LO_FLAG] <= 1'b1;
				if (here) cfg_q[g][`VM_CH_DONE] <= 1'b1;
			end
		end

		// Result and limits of one channel
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				res_q[g] <= `VM_RST_ZERO;
				hi_q[g]  <= `VM_RST_HI_LIMIT;
				lo_q[g]  <= `VM_RST_LO_LIMIT;
			end else begin
				if (here) res_q[g] <= conv_data;
				if (wr_hi && sel) hi_q[g] <= reg_wdata;
				if (wr_lo && sel) lo_q[g] <= reg_wdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Scan period timer
	// ------------------------------------------------------------

	// Counts while enabled; expiry requests a fresh scan
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			per_cnt_q  <= '0;
			scan_req_q <= 1'b0;
		end else if (!mon_en) begin
			per_cnt_q  <= '0;
			scan_req_q <= 1'b0;
		end else if (per_cnt_q == 32'd0) begin
			per_cnt_q  <= per_load;
			scan_req_q <= 1'b1;
		end else begin
			per_cnt_q  <= per_cnt_q - 32'd1;
			if ((state_q == vm_pkg::VM_IDLE) && scan_req_q) begin
				scan_req_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------

	// Walks enabled channels upward, settling between conversions
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= vm_pkg::VM_IDLE;
			chan_q    <= 4'h0;
			dly_cnt_q <= '0;
		end else if (!mon_en) begin
			state_q   <= vm_pkg::VM_IDLE;
		end else begin
			case (state_q)
				vm_pkg::VM_IDLE: begin
					// Begin a scan at the lowest enabled channel
					if (scan_req_q && !first_ch[4]) begin
						chan_q  <= first_ch[3:0];
						state_q <= vm_pkg::VM_START;
					end
				end
				vm_pkg::VM_START: begin
					state_q <= vm_pkg::VM_WAIT;
				end
				vm_pkg::VM_WAIT: begin
					// Result stored by the bank on the same edge
					if (conv_done) begin
						dly_cnt_q <= dly_load;
						state_q   <= vm_pkg::VM_SETTLE;
					end
				end
				vm_pkg::VM_SETTLE: begin
					if (dly_cnt_q != 32'd0) begin
						dly_cnt_q <= dly_cnt_q - 32'd1;
					end else if (!next_ch[4]) begin
						chan_q  <= next_ch[3:0];
						state_q <= vm_pkg::VM_START;
					end else begin
						state_q <= vm_pkg::VM_IDLE;
					end
				end
				default: begin
					state_q <= vm_pkg::VM_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata               = rdata_q;
	assign conv_start              = (state_q == vm_pkg::VM_START);
	assign conv_chan               = chan_q;
	assign conv_ref_ext            = mon_cfg_q[`VM_MON_EXT_REF];
	assign irq                     = irq_q;
	assign system_mgmt_interrupt_n = mgmt_n_q;

endmodule : vm_voltage_monitor

`default_nettype wire

/* File: logic/vm_defines.svh */
`ifndef VM_DEFINES_SVH
`define VM_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define VM_OFS_EVT_LO     8'h00
`define VM_OFS_EVT_HI     8'h01
`define VM_OFS_MGMT_HI    8'h02
`define VM_OFS_MGMT_LO    8'h03
`define VM_OFS_IRQ_HI     8'h04
`define VM_OFS_IRQ_LO     8'h05
`define VM_OFS_RATE       8'h07
`define VM_OFS_MON_CFG    8'h08
`define VM_OFS_BANK       8'h09
`define VM_OFS_CH_CFG     8'h0A
`define VM_OFS_CH_RES     8'h0B
`define VM_OFS_CH_HI      8'h0C
`define VM_OFS_CH_LO      8'h0D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VM_MON_ENABLE     0
`define VM_MON_EXT_REF    1
`define VM_CH_ENABLE      0
`define VM_CH_HI_FLAG     1
`define VM_CH_LO_FLAG     2
`define VM_CH_ALARM_EN    4
`define VM_CH_DONE        7
`define VM_RATE_PER_LSB   0
`define VM_RATE_DLY_LSB   3
`define VM_CH_RW_MASK     8'h79
`define VM_CH_W1C_MASK    8'h86

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VM_RST_MON_CFG    8'h02
`define VM_RST_BANK       8'h00
`define VM_RST_RATE       8'h00
`define VM_RST_HI_LIMIT   8'hFF
`define VM_RST_LO_LIMIT   8'h00
`define VM_RST_ZERO       8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define VM_CLK_MHZ        40
`define VM_PERIOD_UNIT_US 1000
`define VM_DELAY_UNIT_US  40
`define VM_PERIOD_UNIT_CYC (`VM_PERIOD_UNIT_US * `VM_CLK_MHZ)
`define VM_DELAY_UNIT_CYC  (`VM_DELAY_UNIT_US * `VM_CLK_MHZ)

`endif

/* File: logic/vm_pkg.sv */
`default_nettype none

package vm_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		VM_IDLE   = 3'b000,
		VM_START  = 3'b001,
		VM_WAIT   = 3'b010,
		VM_SETTLE = 3'b011
	} vm_state_e;

	// One register byte
	typedef logic [7:0] vm_byte_t;

endpackage : vm_pkg

`default_nettype wire

/* File: tb/vm_voltage_monitor_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vm_defines.svh"

// ----------------------------------------------------------------
// Port checker for the voltage monitor
// ----------------------------------------------------------------
module vm_voltage_monitor_asserts #(
	parameter int unsigned DELAY_UNIT_CYC = `VM_DELAY_UNIT_CYC
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       conv_start,
	input wire logic [3:0] conv_chan,
	input wire logic       conv_ref_ext,
	input wire logic       conv_done,
	input wire logic [7:0] conv_data,
	input wire logic       irq,
	input wire logic       system_mgmt_interrupt_n
);
	logic [15:0] irq_sh_q;  // Shadow of both irq routes, high byte above
	logic [15:0] mgt_sh_q;  // Shadow of both mgmt routes, high byte above
	logic        mon_sh_q;  // Shadow of the monitor enable
	logic [15:0] gap_q;     // Cycles since the last conversion end

	// Shadows follow register writes; ignore others
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_sh_q <= 16'h0000;
			mgt_sh_q <= 16'h0000;
			mon_sh_q <= 1'b0;
		end else if (reg_wr) begin
			if (reg_addr == `VM_OFS_IRQ_LO || reg_addr == `VM_OFS_IRQ_HI) begin
				irq_sh_q <= (reg_addr == `VM_OFS_IRQ_LO) ? {irq_sh_q[15:8], reg_wdata}
				                                         : {reg_wdata & 8'h07, irq_sh_q[7:0]};
			end
			if (reg_addr == `VM_OFS_MGMT_LO || reg_addr == `VM_OFS_MGMT_HI) begin
				mgt_sh_q <= (reg_addr == `VM_OFS_MGMT_LO) ? {mgt_sh_q[15:8], reg_wdata}
				                                          : {reg_wdata & 8'h07, mgt_sh_q[7:0]};
			end
			if (reg_addr == `VM_OFS_MON_CFG) begin
				mon_sh_q <= reg_wdata[0];
			end
		end
	end

	// Settle counter, saturating, cleared by a conversion end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 16'hFFFF;
		end else if (conv_done) begin
			gap_q <= 16'h0000;
		end else if (gap_q != 16'hFFFF) begin
			gap_q <= gap_q + 16'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_irq_quiet;
		(irq_sh_q == 16'h0000 && irq_sh_q == $past(irq_sh_q)) [*3];
	endsequence
	sequence s_mgt_quiet;
		(mgt_sh_q == 16'h0000 && mgt_sh_q == $past(mgt_sh_q)) [*3];
	endsequence

	AST_START_PULSE: assert property (conv_start |=> !conv_start)
		else $error("conversion start held longer than one cycle");
	AST_SETTLE: assert property (conv_start |-> gap_q >= DELAY_UNIT_CYC)
		else $error("conversion started inside the settling delay");
	AST_CHAN_HOLD: assert property (conv_start |-> ##1 $stable(conv_chan) [*2])
		else $error("channel changed during a conversion");
	AST_START_EN: assert property (conv_start |-> mon_sh_q || $past(mon_sh_q))
		else $error("conversion started while monitor disabled");
	AST_REF: assert property (reg_wr && reg_addr == `VM_OFS_MON_CFG |=> conv_ref_ext == $past(reg_wdata[1]))
		else $error("reference select does not follow config write");
	AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata == 8'h00)
		else $error("unmapped offset read nonzero");
	AST_IRQ_MASK: assert property (s_irq_quiet |-> !irq)
		else $error("irq active with all routes off");
	AST_MGMT_MASK: assert property (s_mgt_quiet |-> system_mgmt_interrupt_n)
		else $error("management interrupt active with all routes off");
	COV_DONE: cover property (conv_done ##[1:40] conv_start);
endmodule : vm_voltage_monitor_asserts

bind vm_voltage_monitor vm_voltage_monitor_asserts #(.DELAY_UNIT_CYC(DELAY_UNIT_CYC)) u_vm_asserts (
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
	.conv_chan(conv_chan), .conv_ref_ext(conv_ref_ext), .conv_done(conv_done),
	.conv_data(conv_data), .irq(irq), .system_mgmt_interrupt_n(system_mgmt_interrupt_n));

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vm_defines.svh"

module tb;
	logic            clk, rst_n, reg_wr, reg_rd, conv_done;  // Bench-driven controls
	logic      [7:0] reg_addr, reg_wdata, conv_data;          // Bench-driven buses
	logic      [7:0] reg_rdata;                               // Read data from block
	logic            conv_start, conv_ref_ext, irq, mgmt_n;   // Block outputs
	logic      [3:0] conv_chan;                               // Channel being converted
	vm_pkg::vm_byte_t conv_tbl [0:15];                        // Converter answers
	int              n_mismatch, n_checks, cyc, t_done;       // Counters and stamps
	int              seen_q [$];                              // Channels converted
	int              gap_q [$];                               // Settle gaps

	vm_voltage_monitor #(.PERIOD_UNIT_CYC(50), .DELAY_UNIT_CYC(4)) u_vm_voltage_monitor (
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
		.conv_chan(conv_chan), .conv_ref_ext(conv_ref_ext), .conv_done(conv_done),
		.conv_data(conv_data), .irq(irq), .system_mgmt_interrupt_n(mgmt_n));

	// ----------------------------------------------------------------
	// Clock, cycle count, converter stand-in
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	// Answers each start after three cycles; data is scrambled outside done
	initial forever begin
		@(negedge clk);
		if (conv_start === 1'b1) begin
			seen_q.push_back(int'(conv_chan));
			if (seen_q.size() > 1) gap_q.push_back(cyc - t_done);
			repeat (3) @(negedge clk);
			conv_data = conv_tbl[conv_chan];
			conv_done = 1'b1;
			@(posedge clk) t_done = cyc;
			@(negedge clk);
			conv_done = 1'b0;
			conv_data = ~conv_data;
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		check(what, reg_rdata, exp);
	endtask : rdchk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rdchk(`VM_OFS_BANK, 8'h00, "bank");
		rdchk(`VM_OFS_MON_CFG, 8'h02, "mon_cfg");
		check("ref_ext", {7'h00, conv_ref_ext}, 8'h01);
		rdchk(`VM_OFS_CH_HI, 8'hFF, "hi_limit");
		rdchk(`VM_OFS_EVT_LO, 8'h00, "evt_lo");
		rdchk(8'h06, 8'h00, "unmapped");
	endtask : t_reset
	// Distinct limits per bank, then an absent bank
	task automatic t_banks;
		for (int b = 0; b < 3; b++) begin
			wr(`VM_OFS_BANK, 8'(b));
			wr(`VM_OFS_CH_HI, 8'(8'h10 + b));
		end
		for (int b = 0; b < 3; b++) begin
			wr(`VM_OFS_BANK, 8'(b));
			rdchk(`VM_OFS_CH_HI, 8'(8'h10 + b), "bank_hi");
		end
		wr(`VM_OFS_BANK, 8'h0B);
		rdchk(`VM_OFS_CH_HI, 8'h00, "bank_absent");
		wr(`VM_OFS_RATE, 8'h08);
		rdchk(`VM_OFS_RATE, 8'h08, "rate");
		wr(`VM_OFS_MON_CFG, 8'h00);
		check("ref_int", {7'h00, conv_ref_ext}, 8'h00);
		wr(`VM_OFS_MON_CFG, 8'h02);
	endtask : t_banks
	// One scan of channels 1, 3, 9; alarm only on 3
	task automatic t_scan;
		conv_tbl[1] = 8'hF0;
		conv_tbl[3] = 8'h90;
		conv_tbl[9] = 8'hFF;
		wr(`VM_OFS_BANK, 8'h01);
		wr(`VM_OFS_CH_CFG, 8'h01);
		wr(`VM_OFS_BANK, 8'h03);
		wr(`VM_OFS_CH_HI, 8'h80);
		wr(`VM_OFS_CH_CFG, 8'h11);
		wr(`VM_OFS_BANK, 8'h09);
		wr(`VM_OFS_CH_HI, 8'hFF);
		wr(`VM_OFS_CH_CFG, 8'h01);
		wr(`VM_OFS_EVT_LO, 8'hFF);
		wr(`VM_OFS_MON_CFG, 8'h03);
		for (int i = 0; i < 400 && seen_q.size() < 3; i++) @(posedge clk);
		repeat (8) @(posedge clk);
		wr(`VM_OFS_MON_CFG, 8'h02);
		check("order0", 8'(seen_q[0]), 8'h01);
		check("order1", 8'(seen_q[1]), 8'h03);
		check("order2", 8'(seen_q[2]), 8'h09);
		check("settle", {7'h00, gap_q[0] >= 8}, 8'h01);
		wr(`VM_OFS_BANK, 8'h01);
		rdchk(`VM_OFS_CH_CFG, 8'h81, "cfg1");
		rdchk(`VM_OFS_CH_RES, 8'hF0, "res1");
		wr(`VM_OFS_BANK, 8'h03);
		rdchk(`VM_OFS_CH_CFG, 8'h93, "cfg3");
		wr(`VM_OFS_BANK, 8'h09);
		rdchk(`VM_OFS_CH_RES, 8'hFF, "res9");
		rdchk(`VM_OFS_CH_CFG, 8'h81, "cfg9");
		wr(`VM_OFS_BANK, 8'h00);
		rdchk(`VM_OFS_CH_CFG, 8'h00, "cfg0");
		rdchk(`VM_OFS_EVT_LO, 8'h08, "evt_lo");
		rdchk(`VM_OFS_EVT_HI, 8'h00, "evt_hi");
	endtask : t_scan
	// Routing masks, then write-one-clear of flags
	task automatic t_irq_w1c;
		check("irq_off", {7'h00, irq}, 8'h00);
		wr(`VM_OFS_IRQ_LO, 8'h08);
		repeat (2) @(negedge clk);
		check("irq_on", {7'h00, irq}, 8'h01);
		check("mgmt_off", {7'h00, mgmt_n}, 8'h01);
		wr(`VM_OFS_MGMT_LO, 8'h08);
		repeat (2) @(negedge clk);
		check("mgmt_on", {7'h00, mgmt_n}, 8'h00);
		wr(`VM_OFS_IRQ_LO, 8'h04);
		repeat (2) @(negedge clk);
		check("irq_other", {7'h00, irq}, 8'h00);
		wr(`VM_OFS_BANK, 8'h03);
		wr(`VM_OFS_CH_CFG, 8'h11);
		rdchk(`VM_OFS_CH_CFG, 8'h93, "cfg_keep");
		wr(`VM_OFS_CH_CFG, 8'h97);
		rdchk(`VM_OFS_CH_CFG, 8'h11, "cfg_clear");
		wr(`VM_OFS_EVT_LO, 8'h00);
		rdchk(`VM_OFS_EVT_LO, 8'h08, "evt_keep");
		wr(`VM_OFS_EVT_LO, 8'h08);
		rdchk(`VM_OFS_EVT_LO, 8'h00, "evt_clear");
		repeat (2) @(negedge clk);
		check("mgmt_drop", {7'h00, mgmt_n}, 8'h01);
	endtask : t_irq_w1c

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, conv_done, reg_addr, reg_wdata, conv_data} = '0;
		{n_mismatch, n_checks, cyc, t_done} = '0;
		foreach (conv_tbl[i]) conv_tbl[i] = 8'h40;
		repeat (16) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		t_reset;
		t_banks;
		t_scan;
		t_irq_w1c;
		report_and_stop;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		report_and_stop;
	end
endmodule : tb

`default_nettype wire
